// [logic/dskad_top.sv]
// Purpose: Glue between the I/O channel, the diskette controller and drives
// Assumes: Controller core sits outside and talks over ctl ports
// Notes:   Drive outputs are open collector: oe low pulls the line low
//
// Operation
// - Bit 7 runs fourth motor; reset clears.
// - Address ignored while AEN active.
// - Write latches data at strobe end.
// - Read drives addressed register onto bus.
// - DACK selects data register, drops DRQ.
// - TC with DACK ends the transfer.
// - Channel reset aborts and clears register.
// - DRQ raised when ready, dropped on service.
// - IRQ on completion, cleared by results.
// - Direction set before each step pulse.
// - Head select low picks head 1.
// - Write data edges only with write enable.
// - Bits 1:0 choose the selected drive.
// - Bit 3 gates IRQ and DRQ outward.
// - Bits 4 to 6 run motors A-C.
`timescale 1ns/100ps
module dskad_top #(
	parameter int DRIVES = 4
) (
	input  wire logic        clock_in,
	input  wire logic        nrst_in,
	input  wire logic        chan_reset_in,
	input  wire logic [9:0]  chan_addr_in,
	input  wire logic [7:0]  chan_data_in,
	output logic      [7:0]  chan_data_out,
	output logic             chan_data_oe_out,
	input  wire logic        chan_aen_in,
	input  wire logic        chan_iow_n_in,
	input  wire logic        chan_ior_n_in,
	input  wire logic        chan_dack2_n_in,
	input  wire logic        chan_tc_in,
	output logic             chan_drq2_out,
	output logic             chan_irq6_out,
	input  wire dskad_pkg::dskad_ctl_t ctl_in,
	input  wire logic [7:0]  ctl_status_in,
	output logic             ctl_reset_out,
	output logic             ctl_data_wr_out,
	output logic             ctl_data_rd_out,
	output logic             ctl_status_rd_out,
	output logic [7:0]       ctl_wdata_out,
	output logic             ctl_dack_out,
	output logic             ctl_tc_out,
	output dskad_pkg::dskad_drv_t ctl_drv_out,
	output logic [DRIVES-1:0] drv_select_out,
	output logic [DRIVES-1:0] drv_motor_out,
	output logic             drv_step_out,
	output logic             drv_dir_out,
	output logic             drv_head1_out,
	output logic             drv_wdata_out,
	output logic             drv_wgate_out,
	input  wire logic        drv_index_n_in,
	input  wire logic        drv_wprot_n_in,
	input  wire logic        drv_trk0_n_in,
	input  wire logic        drv_rdata_n_in
);
	import dskad_pkg::*;

	localparam int CHW = $bits(dskad_chan_t);
	localparam int DVW = $bits(dskad_drv_t);

	typedef struct packed {
		logic [7:0]        doc;
		logic              iow_d;
		logic              ior_d;
		logic [9:0]        wr_addr;
		logic              wr_dack;
		logic [7:0]        wr_data;
		logic [7:0]        bus;
		logic              bus_oe;
		logic              drq;
		logic              irq;
		logic              tc_end;
		logic              ctl_reset;
		logic              data_wr;
		logic              data_rd;
		logic              stat_rd;
		logic [7:0]        wdata;
		logic              dack;
		logic              tc;
		dskad_drv_t        drv;
		logic [DRIVES-1:0] sel_oe;
		logic [DRIVES-1:0] mot_oe;
		logic              step_oe;
		logic              dir_oe;
		logic              head_oe;
		logic              wd_oe;
		logic              wg_oe;
	} dskad_state_t;

	dskad_state_t state;
	dskad_state_t next_state;
	dskad_chan_t  chan;
	dskad_drv_t   drv;
	logic         rst_sync;

	// Channel pins come from outside the clock domain
	dskad_sync #(.WIDTH(CHW + 1)) u_chan_sync (
		.clock_in (clock_in),
		.nrst_in  (nrst_in),
		.async_in ({chan_addr_in, chan_data_in, chan_aen_in, ~chan_iow_n_in,
			~chan_ior_n_in, ~chan_dack2_n_in, chan_tc_in, chan_reset_in}),
		.sync_out ({chan, rst_sync})
	);

	// Drive inputs are active low on the cable
	dskad_sync #(.WIDTH(DVW)) u_drv_sync (
		.clock_in (clock_in),
		.nrst_in  (nrst_in),
		.async_in ({~drv_index_n_in, ~drv_wprot_n_in, ~drv_trk0_n_in, ~drv_rdata_n_in}),
		.sync_out (drv)
	);

	// Address decode, qualified by AEN
	function automatic logic hit(input logic [9:0] a, input logic aen,
			input logic [9:0] port);
		hit = !aen && (a == port);
	endfunction

	always_comb begin
		next_state          = state;
		next_state.iow_d    = chan.iow;
		next_state.ior_d    = chan.ior;
		next_state.data_wr  = 1'b0;
		next_state.data_rd  = 1'b0;
		next_state.stat_rd  = 1'b0;
		next_state.tc_end   = 1'b0;
		next_state.dack     = chan.dack;
		next_state.drv      = drv;

		// AEN masks address; capture while strobe is active
		if (chan.iow) begin
			next_state.wr_addr = chan.addr;
			next_state.wr_dack = chan.dack;
			next_state.wr_data = chan.data;
		end

		// latch at trailing edge of write strobe
		if (state.iow_d && !chan.iow) begin
			if (state.wr_dack) begin
				next_state.data_wr = 1'b1;
				next_state.wdata   = state.wr_data;
			end else if (hit(state.wr_addr, chan.aen, DSKAD_ADDR_DOC)) begin
				next_state.doc = state.wr_data;
			end else if (hit(state.wr_addr, chan.aen, DSKAD_ADDR_DATA)) begin
				next_state.data_wr = 1'b1;
				next_state.wdata   = state.wr_data;
			end
		end

		// gate addressed register while read is active
		// DACK selects data register regardless of address
		next_state.bus_oe = 1'b0;
		next_state.bus    = 8'h00;
		if (chan.ior) begin
			if (chan.dack || hit(chan.addr, chan.aen, DSKAD_ADDR_DATA)) begin
				next_state.bus_oe = 1'b1;
				next_state.bus    = ctl_in.rdata;
			end else if (hit(chan.addr, chan.aen, DSKAD_ADDR_DOC)) begin
				next_state.bus_oe = 1'b1;
				next_state.bus    = state.doc;
			end else if (hit(chan.addr, chan.aen, DSKAD_ADDR_STATUS)) begin
				next_state.bus_oe = 1'b1;
				next_state.bus    = ctl_status_in;
			end
		end

		// Read side effect pulses on the leading edge only
		if (chan.ior && !state.ior_d) begin
			if (chan.dack || hit(chan.addr, chan.aen, DSKAD_ADDR_DATA)) begin
				next_state.data_rd = 1'b1;
			end else if (hit(chan.addr, chan.aen, DSKAD_ADDR_STATUS)) begin
				next_state.stat_rd = 1'b1;
			end
		end

		// TC only counts together with DACK
		next_state.tc = chan.tc && chan.dack;
		if (chan.tc && chan.dack) begin
			next_state.tc_end = 1'b1;
		end

		// DRQ follows controller, dropped on DACK or data read
		next_state.drq = ctl_in.drq && state.doc[DSKAD_DOC_REQ_EN] && !chan.dack
			&& !next_state.data_rd;
		// controller holds IRQ until results are read
		next_state.irq = ctl_in.irq && state.doc[DSKAD_DOC_REQ_EN];

		// bit 2 low holds controller in reset
		next_state.ctl_reset = !state.doc[DSKAD_DOC_RUN];

		// bits 1:0 pick the drive; low oe pulls select active
		for (int i = 0; i < DRIVES; i++) begin
			next_state.sel_oe[i] =
				(state.doc[DSKAD_DOC_SEL_HI:DSKAD_DOC_SEL_LO] != 2'(i));
			// motor bits 4 to 6; bit 7 for fourth drive
			next_state.mot_oe[i] = !state.doc[DSKAD_DOC_MOTOR_LO + i];
		end

		// direction passes straight, controller orders it before step
		next_state.step_oe = !ctl_in.step;
		next_state.dir_oe  = !ctl_in.dir;
		// head 1 pulls the line low
		next_state.head_oe = !ctl_in.head;
		// write data only passes while write gate is on
		next_state.wd_oe   = !(ctl_in.wdata && ctl_in.wgate);
		next_state.wg_oe   = !ctl_in.wgate;

		// channel reset clears the register and aborts
		if (rst_sync) begin
			next_state.doc       = DSKAD_DOC_RESET;
			next_state.drq       = 1'b0;
			next_state.irq       = 1'b0;
			next_state.ctl_reset = 1'b1;
			next_state.data_wr   = 1'b0;
		end
		if (!nrst_in) begin
			next_state         = '0;
			next_state.doc     = DSKAD_DOC_RESET;
			next_state.ctl_reset = 1'b1;
			// Code 00 decodes to the first drive, so reset matches the decode
			next_state.sel_oe  = ~DRIVES'(1'b1);
			next_state.mot_oe  = '1;
			next_state.step_oe = 1'b1;
			next_state.dir_oe  = 1'b1;
			next_state.head_oe = 1'b1;
			next_state.wd_oe   = 1'b1;
			next_state.wg_oe   = 1'b1;
		end
	end

	// Single state register, synchronous reset handled above
	always_ff @(posedge clock_in) begin
		state <= next_state;
	end

	// Outputs straight from flops; open collector drives constant low
	assign chan_data_out     = state.bus;
	assign chan_data_oe_out  = state.bus_oe;
	assign chan_drq2_out     = state.drq;
	assign chan_irq6_out     = state.irq;
	assign ctl_reset_out     = state.ctl_reset;
	assign ctl_data_wr_out   = state.data_wr;
	assign ctl_data_rd_out   = state.data_rd;
	assign ctl_status_rd_out = state.stat_rd;
	assign ctl_wdata_out     = state.wdata;
	assign ctl_dack_out      = state.dack;
	assign ctl_tc_out        = state.tc;
	assign ctl_drv_out       = state.drv;
	assign drv_select_out    = state.sel_oe;
	assign drv_motor_out     = state.mot_oe;
	assign drv_step_out      = state.step_oe;
	assign drv_dir_out       = state.dir_oe;
	assign drv_head1_out     = state.head_oe;
	assign drv_wdata_out     = state.wd_oe;
	assign drv_wgate_out     = state.wg_oe;

	// Assertions
	doc_reset_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		rst_sync |=> state.doc == DSKAD_DOC_RESET) else $error("doc not cleared");
	motor4_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		state.doc[DSKAD_DOC_MOTOR_HI] |=> !drv_motor_out[DRIVES-1])
		else $error("fourth motor not driven");
	aen_block_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(chan.ior && chan.aen && !chan.dack) |=> !chan_data_oe_out)
		else $error("decode during aen");
	write_doc_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(state.iow_d && !chan.iow && !state.wr_dack && !rst_sync
		&& hit(state.wr_addr, chan.aen, DSKAD_ADDR_DOC)) |=> state.doc == $past(state.wr_data))
		else $error("doc write lost");
	read_doc_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(chan.ior && !chan.dack && hit(chan.addr, chan.aen, DSKAD_ADDR_DOC))
		|=> chan_data_oe_out && chan_data_out == $past(state.doc))
		else $error("doc read wrong");
	dack_drq_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		chan.dack |=> !chan_drq2_out) else $error("drq with dack");
	tc_end_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		(chan.tc && !chan.dack) |=> !ctl_tc_out) else $error("tc without dack");
	drq_read_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		ctl_data_rd_out |-> !chan_drq2_out) else $error("drq after data read");
	irq_gate_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		!state.doc[DSKAD_DOC_REQ_EN] |=> !chan_irq6_out) else $error("irq not gated");
	select_one_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		$onehot(~drv_select_out)) else $error("select not one");
	head_pin_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		ctl_in.head |=> !drv_head1_out) else $error("head select wrong");
	wgate_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		drv_wgate_out |-> drv_wdata_out) else $error("write data without gate");
	ctl_run_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		!state.doc[DSKAD_DOC_RUN] |=> ctl_reset_out) else $error("controller run");
	motor_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		state.doc[DSKAD_DOC_MOTOR_LO] |=> !drv_motor_out[0]) else $error("motor a");
	dir_a: assert property (@(posedge clock_in) disable iff (!nrst_in)
		ctl_in.dir |=> !drv_dir_out) else $error("direction lost");

	dma_cov: cover property (@(posedge clock_in) state.tc_end);
	wr_cov: cover property (@(posedge clock_in) ctl_data_wr_out);
	irq_cov: cover property (@(posedge clock_in) chan_irq6_out);
endmodule

// [logic/dskad_pkg.sv]
// Purpose: Shared constants and carriers for the diskette adapter glue logic
// Assumes: 125 MHz channel clock, byte-wide I/O channel
// Notes:   Port addresses are channel I/O addresses, ten bits wide
package dskad_pkg;

	// Channel I/O addresses
	localparam logic [9:0] DSKAD_ADDR_DOC    = 10'h3F2;
	localparam logic [9:0] DSKAD_ADDR_STATUS = 10'h3F4;
	localparam logic [9:0] DSKAD_ADDR_DATA   = 10'h3F5;

	// Field positions in digital_output_control
	localparam int DSKAD_DOC_SEL_LO   = 0;
	localparam int DSKAD_DOC_SEL_HI   = 1;
	localparam int DSKAD_DOC_RUN      = 2;
	localparam int DSKAD_DOC_REQ_EN   = 3;
	localparam int DSKAD_DOC_MOTOR_LO = 4;
	localparam int DSKAD_DOC_MOTOR_HI = 7;
	localparam logic [7:0] DSKAD_DOC_RESET = 8'h00;

	// Drive timing that software must respect
	localparam int DSKAD_CLK_MHZ        = 125;
	localparam int DSKAD_HEAD_LOAD_MS   = 35;
	localparam int DSKAD_HEAD_SETTLE_MS = 15;
	localparam int DSKAD_MOTOR_START_MS = 250;
	localparam longint DSKAD_HEAD_LOAD_CYC   = longint'(DSKAD_HEAD_LOAD_MS) * 1000 * DSKAD_CLK_MHZ;
	localparam longint DSKAD_HEAD_SETTLE_CYC = longint'(DSKAD_HEAD_SETTLE_MS) * 1000 * DSKAD_CLK_MHZ;
	localparam longint DSKAD_MOTOR_START_CYC = longint'(DSKAD_MOTOR_START_MS) * 1000 * DSKAD_CLK_MHZ;

	// Controller programming constants
	localparam logic [3:0] DSKAD_STEP_RATE_TIME   = 4'hC;
	localparam logic [3:0] DSKAD_HEAD_UNLOAD_TIME = 4'hF;
	localparam logic [6:0] DSKAD_HEAD_LOAD_TIME   = 7'h01;
	localparam logic [7:0] DSKAD_SECTOR_SIZE      = 8'h02;
	localparam logic [7:0] DSKAD_SECTORS_PER_TRACK = 8'h08;
	localparam logic [7:0] DSKAD_GAP_LENGTH_RW    = 8'h2A;
	localparam logic [7:0] DSKAD_GAP_LENGTH_FMT   = 8'h05;

	// Host channel inputs after synchronising
	typedef struct packed {
		logic [9:0] addr;
		logic [7:0] data;
		logic       aen;
		logic       iow;
		logic       ior;
		logic       dack;
		logic       tc;
	} dskad_chan_t;

	// Controller side of the adapter
	typedef struct packed {
		logic       drq;
		logic       irq;
		logic       step;
		logic       dir;
		logic       head;
		logic       wdata;
		logic       wgate;
		logic [7:0] rdata;
	} dskad_ctl_t;

	// Drive inputs, active high after inversion
	typedef struct packed {
		logic index;
		logic wprot;
		logic trk0;
		logic rdata;
	} dskad_drv_t;

endpackage

// [logic/dskad_sync.sv]
// Purpose: Two-stage synchroniser for a bundle of asynchronous inputs
// Assumes: Each bit is independent; buses are qualified by strobes later
// Notes:   First stage is read only by the second stage
`timescale 1ns/100ps
module dskad_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock_in,
	input  wire logic             nrst_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} dskad_sync_t;

	dskad_sync_t state;
	dskad_sync_t next_state;

	// Shift through two flops
	always_comb begin
		next_state.meta   = async_in;
		next_state.stable = state.meta;
		if (!nrst_in) begin
			next_state = '0;
		end
	end

	always_ff @(posedge clock_in) begin
		state <= next_state;
	end

	assign sync_out = state.stable;
endmodule

// [bench/dskad_host.sv]
// Purpose: Host channel model: processor I/O cycles, DMA and channel reset
// Assumes: Strobes held 5 clocks and spaced at least 6 apart, above the 4-clock minimum
// Notes:   Released address and data show the inverse of their last value; AEN returns to 0
`timescale 1ns/100ps
module dskad_host (
	input  wire logic       clock_in,
	input  wire logic [7:0] dev_data_in,
	input  wire logic       dev_oe_in,
	output logic            reset_out,
	output logic [9:0]      addr_out,
	output logic [7:0]      data_out,
	output logic            aen_out,
	output logic            iow_n_out,
	output logic            ior_n_out,
	output logic            dack2_n_out,
	output logic            tc_out
);
	// Idle channel from time zero
	initial begin
		reset_out = 1'b0;
		addr_out = 10'h000;
		data_out = 8'h00;
		aen_out = 1'b0;
		iow_n_out = 1'b1;
		ior_n_out = 1'b1;
		dack2_n_out = 1'b1;
		tc_out = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clock_in);
	endtask

	// Inverse on release so a stale value can never pass for a fresh one
	task automatic release_bus();
		addr_out <= ~addr_out;
		data_out <= ~data_out;
		aen_out <= 1'b0;
	endtask

	// Write cycle; address and data held past the trailing strobe edge
	task automatic io_write(input logic [9:0] a, input logic [7:0] d, input logic en);
		@(posedge clock_in);
		addr_out <= a;
		data_out <= d;
		aen_out <= en;
		iow_n_out <= 1'b0;
		wait_clk(5);
		iow_n_out <= 1'b1;
		wait_clk(6);
		release_bus();
		wait_clk(5);
	endtask

	// Read cycle; the bus is sampled at the last edge of the strobe
	task automatic io_read(input logic [9:0] a, input logic en,
			output logic [7:0] d, output logic oe);
		@(posedge clock_in);
		addr_out <= a;
		aen_out <= en;
		ior_n_out <= 1'b0;
		wait_clk(5);
		d = dev_data_in;
		oe = dev_oe_in;
		ior_n_out <= 1'b1;
		release_bus();
		wait_clk(5);
	endtask

	task automatic dma(input logic ack, input logic last);
		@(posedge clock_in);
		dack2_n_out <= ~ack;
		tc_out <= ack & last;
	endtask

	task automatic chan_reset(input logic v);
		@(posedge clock_in);
		reset_out <= v;
	endtask
endmodule

// [bench/testbench.sv]
// Purpose: Self-checking bench for the diskette adapter glue
// Assumes: Host model drives the channel; bench drives controller and drives
// Notes:   Drive outputs are enables: 0 means the line is pulled active
`timescale 1ns/100ps
module testbench;
	import dskad_pkg::*;
	logic       clock_in = 1'b0;
	logic       nrst_in = 1'b0;
	logic       rst, aen, iow_n, ior_n, dack_n, tc, oe;
	logic [9:0] addr;
	logic [7:0] din, dout, ctl_status, rd_d;
	logic       rd_oe, ctl_reset, data_wr, data_rd, status_rd, dack_o, tc_o;
	logic       drq, irq, step, dir, head1, wdata, wgate;
	logic [7:0] wdata_o;
	logic [3:0] sel, motor, drv_n;
	dskad_ctl_t ctl = '0;
	dskad_drv_t drv_o;
	int         n_errors = 0, n_compared = 0, cycles = 0, wr_seen, rd_seen, st_seen;
	logic [7:0] wr_last;

	always #4 clock_in = ~clock_in;

	dskad_host host (.clock_in(clock_in), .dev_data_in(dout), .dev_oe_in(oe),
		.reset_out(rst), .addr_out(addr), .data_out(din), .aen_out(aen),
		.iow_n_out(iow_n), .ior_n_out(ior_n), .dack2_n_out(dack_n), .tc_out(tc));

	dskad_top #(.DRIVES(4)) i_dskad_top (.clock_in(clock_in), .nrst_in(nrst_in),
		.chan_reset_in(rst), .chan_addr_in(addr), .chan_data_in(din),
		.chan_data_out(dout), .chan_data_oe_out(oe), .chan_aen_in(aen),
		.chan_iow_n_in(iow_n), .chan_ior_n_in(ior_n), .chan_dack2_n_in(dack_n),
		.chan_tc_in(tc), .chan_drq2_out(drq), .chan_irq6_out(irq), .ctl_in(ctl),
		.ctl_status_in(ctl_status), .ctl_reset_out(ctl_reset),
		.ctl_data_wr_out(data_wr), .ctl_data_rd_out(data_rd),
		.ctl_status_rd_out(status_rd), .ctl_wdata_out(wdata_o),
		.ctl_dack_out(dack_o), .ctl_tc_out(tc_o), .ctl_drv_out(drv_o),
		.drv_select_out(sel), .drv_motor_out(motor), .drv_step_out(step),
		.drv_dir_out(dir), .drv_head1_out(head1), .drv_wdata_out(wdata),
		.drv_wgate_out(wgate), .drv_index_n_in(drv_n[3]), .drv_wprot_n_in(drv_n[2]),
		.drv_trk0_n_in(drv_n[1]), .drv_rdata_n_in(drv_n[0]));

	// Pulse monitors; one-cycle strobes are caught where they stand
	always @(posedge clock_in) begin
		cycles++;
		if (data_wr === 1'b1) begin
			wr_seen++;
			wr_last = wdata_o;
		end
		if (data_rd === 1'b1)
			rd_seen++;
		if (status_rd === 1'b1)
			st_seen++;
		if (cycles == 5000) begin
			n_errors++;
			summarize();
		end
	end

	task automatic summarize();
		if (n_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h got %h", what, exp, got);
		end
	endtask

	// Select is one-hot low, motors and controller reset inverted from the byte
	task automatic check_doc(input logic [7:0] v);
		check("select", {4'h0, ~(4'h1 << v[1:0])}, 8'(sel));
		check("motor", {4'h0, ~v[7:4]}, 8'(motor));
		check("ctl_reset", {7'h00, ~v[2]}, 8'(ctl_reset));
	endtask

	// Controller and drive inputs change just after an edge
	task automatic set_in(input dskad_ctl_t c, input logic [3:0] d);
		@(posedge clock_in);
		ctl <= c;
		drv_n <= d;
		host.wait_clk(4);
	endtask

	// Each value keeps the selected motor on; only 8'hA3 runs a second motor
	logic [7:0] vals [5] = '{8'h14, 8'h25, 8'h46, 8'h87, 8'hA3};
	// Specify and format bytes a driver would hand to the controller
	logic [7:0] spec [7] = '{8'h03, {DSKAD_STEP_RATE_TIME, DSKAD_HEAD_UNLOAD_TIME},
		{DSKAD_HEAD_LOAD_TIME, 1'b0}, DSKAD_SECTOR_SIZE, DSKAD_SECTORS_PER_TRACK,
		DSKAD_GAP_LENGTH_RW, DSKAD_GAP_LENGTH_FMT};

	initial begin
		drv_n = 4'hF;
		ctl_status = 8'h81;
		repeat (5) @(posedge clock_in);
		nrst_in <= 1'b1;
		host.wait_clk(3);
		check_doc(8'h00);
		check("drq_irq", 8'h00, 8'({drq, irq}));
		foreach (vals[i]) begin
			host.io_write(DSKAD_ADDR_DOC, vals[i], 1'b0);
			check_doc(vals[i]);
			host.io_read(DSKAD_ADDR_DOC, 1'b0, rd_d, rd_oe);
			check("doc_read", vals[i], rd_d);
		end
		host.io_write(DSKAD_ADDR_DOC, 8'h00, 1'b1);
		check_doc(8'hA3);
		host.io_read(DSKAD_ADDR_DOC, 1'b1, rd_d, rd_oe);
		check("aen_oe", 8'h00, 8'(rd_oe));
		host.io_write(10'h3F0, 8'h00, 1'b0);
		check_doc(8'hA3);
		host.io_read(10'h3F0, 1'b0, rd_d, rd_oe);
		check("unmapped_oe", 8'h00, 8'(rd_oe));
		wr_seen = 0;
		host.io_write(DSKAD_ADDR_DATA, 8'hA5, 1'b0);
		check("wr_pulses", 8'h01, 8'(wr_seen));
		check("wr_data", 8'hA5, wr_last);
		// no drive transfer is started, so no wait is owed
		wr_seen = 0;
		foreach (spec[i]) begin
			host.io_write(DSKAD_ADDR_DATA, spec[i], 1'b0);
			check("ctl_byte", spec[i], wr_last);
		end
		check("ctl_bytes", 8'h07, 8'(wr_seen));
		ctl.rdata <= 8'h3C;
		rd_seen = 0;
		st_seen = 0;
		host.io_read(DSKAD_ADDR_DATA, 1'b0, rd_d, rd_oe);
		check("data_read", 8'h3C, rd_d);
		check("rd_pulses", 8'h01, 8'(rd_seen));
		host.io_read(DSKAD_ADDR_STATUS, 1'b0, rd_d, rd_oe);
		check("status_read", 8'h81, rd_d);
		check("st_pulses", 8'h01, 8'(st_seen));
		ctl_status <= 8'h5A;
		host.io_read(DSKAD_ADDR_STATUS, 1'b0, rd_d, rd_oe);
		check("status_read2", 8'h5A, rd_d);
		// Requests held back until bit 3 opens the gate
		host.io_write(DSKAD_ADDR_DOC, 8'h14, 1'b0);
		set_in('{drq: 1'b1, irq: 1'b1, rdata: 8'h3C, default: 1'b0}, 4'hF);
		check("gated", 8'h00, 8'({drq, irq}));
		host.io_write(DSKAD_ADDR_DOC, 8'h1C, 1'b0);
		check("open", 8'h03, 8'({drq, irq}));
		host.dma(1'b1, 1'b0);
		host.wait_clk(5);
		check("dack_drq", 8'h01, 8'({drq, dack_o}));
		host.io_read(10'h3F0, 1'b1, rd_d, rd_oe);
		check("dma_read", 8'h3C, rd_d);
		wr_seen = 0;
		host.io_write(10'h3F0, 8'h96, 1'b1);
		check("dma_write", 8'h96, wr_last);
		check("dma_wr_pulses", 8'h01, 8'(wr_seen));
		host.dma(1'b1, 1'b1);
		host.wait_clk(5);
		check("tc_end", 8'h01, 8'(tc_o));
		host.dma(1'b0, 1'b0);
		set_in('{rdata: 8'h3C, default: 1'b0}, 4'hF);
		check("done", 8'h00, 8'({drq, irq, tc_o}));
		// Drive lines: enables low while active, write data needs write gate
		// Drive inputs model the selected drive only; others stay released
		set_in('{step: 1'b1, dir: 1'b1, head: 1'b1, wdata: 1'b1, default: 1'b0}, 4'h7);
		check("drv_lines", 8'h03, 8'({step, dir, head1, wdata, wgate}));
		check("drv_in", 8'h08, 8'(drv_o));
		set_in('{wdata: 1'b1, wgate: 1'b1, default: 1'b0}, 4'h8);
		check("drv_write", 8'h1C, 8'({step, dir, head1, wdata, wgate}));
		check("drv_in2", 8'h07, 8'(drv_o));
		host.io_write(DSKAD_ADDR_DOC, 8'h97, 1'b0);
		host.chan_reset(1'b1);
		host.wait_clk(5);
		check_doc(8'h00);
		host.chan_reset(1'b0);
		host.wait_clk(3);
		// Register must work again once channel reset is gone
		host.io_write(DSKAD_ADDR_DOC, 8'h14, 1'b0);
		check_doc(8'h14);
		summarize();
	end
endmodule
